// ===== inc/cpf_pkg.sv
// cpf_pkg: constants and types for the cpu-style fifo host port
package cpf_pkg;
   // ----------------------------------------
   // status byte layout
   // ----------------------------------------
   localparam int STAT_RX_BIT = 0;
   localparam int STAT_TX_BIT = 1;
   localparam int STAT_SUSP_BIT = 2;
   localparam int STAT_CFG_BIT = 3;
   localparam logic [3:0] STAT_UPPER = 4'h0;
   // ----------------------------------------
   // register select decode
   // ----------------------------------------
   localparam logic SEL_DATA = 1'b0;
   localparam logic SEL_STAT = 1'b1;
   // ----------------------------------------
   // submode command codes
   // ----------------------------------------
   localparam logic [7:0] SUB_RESET = 8'h00;
   localparam logic [7:0] SUB_ABB = 8'h01;
   localparam logic [7:0] SUB_SERENG = 8'h02;
   localparam logic [7:0] SUB_SBB = 8'h04;
   localparam logic [7:0] SUB_FSRST = 8'h10;
   localparam logic [7:0] SUB_SYNCFIFO = 8'h40;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int LED_MS = 50;
   localparam int LED_CYC = LED_MS * (CLK_HZ / 1000);
   localparam int LED_W = 20;
   localparam int WAKE_MS = 20;
   localparam int WAKE_CYC = WAKE_MS * (CLK_HZ / 1000);
   localparam int FLUSH_NS = 250;
   localparam int FLUSH_CYC = (FLUSH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int WAKE_W = 22;
   // ----------------------------------------
   // modes
   // ----------------------------------------
   typedef enum logic [2:0] {
      MD_UART, MD_AFIFO, MD_CPUFIFO, MD_HDLINK, MD_FSER
   } cpf_romode_t;
   typedef enum logic [2:0] {
      RM_NONE, RM_ABB, RM_SBB, RM_SERENG, RM_SFIFO
   } cpf_runmode_t;
   typedef struct packed {
      logic rxPresent;
      logic txFree;
      logic suspended;
      logic configured;
   } cpf_stat_t;
endpackage

// ===== rtl/cpf_buf2.sv
// cpf_buf2: two-entry byte buffer with valid/ready on both sides
`timescale 1ns/1ps
module cpf_buf2
   import cpf_pkg::*;
(
   input wire logic mclk,         // clock
   input wire logic resetn,       // sync reset, low
   input wire logic inValid,      // write side valid
   output logic inReady,          // write side ready
   input wire logic [7:0] inData, // write data
   output logic outValid,         // read side valid
   input wire logic outReady,     // read side ready
   output logic [7:0] outData     // read data
);
   logic [7:0] mem_ff [2];
   logic [7:0] nxt_mem [2];
   logic wp_ff, rp_ff, nxt_wp, nxt_rp;
   logic [1:0] cnt_ff, nxt_cnt;
   logic push, pop;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      push = inValid && (cnt_ff != 2'h2);
      pop = outReady && (cnt_ff != 2'h0);
      nxt_mem = mem_ff;
      nxt_wp = wp_ff;
      nxt_rp = rp_ff;
      nxt_cnt = cnt_ff;
      if (push) begin
         nxt_mem[wp_ff] = inData;
         nxt_wp = ~wp_ff;
      end
      if (pop) begin
         nxt_rp = ~rp_ff;
      end
      nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
   end

   // storage registers
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         mem_ff[0] <= 8'h00;
         mem_ff[1] <= 8'h00;
         wp_ff <= 1'b0;
         rp_ff <= 1'b0;
         cnt_ff <= 2'h0;
      end else begin
         mem_ff <= nxt_mem;
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
         cnt_ff <= nxt_cnt;
      end
   end

   assign inReady = (cnt_ff != 2'h2);
   assign outValid = (cnt_ff != 2'h0);
   assign outData = mem_ff[rp_ff];
endmodule

// ===== rtl/cpf_host_port.sv
// cpf_host_port: cpu-style fifo host port with mode control, flush/wake and leds
//
// What this block does
// - chip select high ignores strobes; address bit picks data pipe or status/send-now.
// - status bits 0..3: rx data, tx space, suspend, configured, all active high.
// - host-port mode entered only from stored eeprom configuration.
// - uart mode offers tx and rx activity indicator outputs.
// - indicators float when idle and pull low while active.
// - one-shot timer stretches indicator activity to a visible pulse.
// - flush/wake pin honoured in all fifo modes and bit-bang modes.
// - send-immediate returns pending tx data as a short packet at once.
// - falling edge of flush/wake pin flags send-immediate to the usb side.
// - with pull-down enabled, no wake from suspend via flush/wake pin.
// - in uart mode the ring indicator pin provides wake-up.
// - default mode with no configuration is uart.
// - after each reset, stored eeprom mode configures the interface.
// - after enumeration, submode command selects bit-bang or serial engine.
// - sync fifo only via code 0x40 and only over stored async fifo.
// - software may hold fast serial in reset; other modes not changeable.
`timescale 1ns/1ps
module cpf_host_port
   import cpf_pkg::*;
(
   input wire logic mclk,                   // 10 MHz clock
   input wire logic resetn,                 // sync reset, low
   // cpu side
   input wire logic chipSelN,               // chip select, low
   input wire logic register_select_bit,    // 0 data pipe, 1 status
   input wire logic rdN,                    // read strobe, low
   input wire logic wrN,                    // write strobe, low
   input wire logic [7:0] dataIn,           // data bus in
   output logic [7:0] dataOut,              // data bus out
   output logic dataOe,                     // data bus drive enable
   // usb core side
   input wire logic eepromValid,            // eeprom config loaded pulse
   input wire cpf_romode_t eepromMode,      // stored mode
   input wire logic pullDownEn,             // pull-down on flush/wake pin
   input wire logic submodeValid,           // submode command pulse
   input wire logic [7:0] interface_submode_cmd, // submode code
   input wire logic enumerated,             // usb enumeration done
   input wire logic usbSuspend,             // usb suspended
   input wire logic usbConfigured,          // usb configured
   input wire logic rxValid,                // rx byte from usb
   output logic rxReady,                    // rx byte accepted
   input wire logic [7:0] rxData,           // rx byte
   output logic txValid,                    // tx byte to usb
   input wire logic txReady,                // usb takes tx byte
   output logic [7:0] txData,               // tx byte
   output logic sendNowReq,                 // short packet request pulse
   output logic wakeReq,                    // remote wake request pulse
   output logic fastSerRst,                 // fast serial held in reset
   output cpf_romode_t romMode,             // active stored mode
   output cpf_runmode_t runMode,            // software submode
   // pins
   input wire logic flush_or_wake_pin,      // flush/wake, low active
   input wire logic ring_indicator_pin,     // ring indicator, low active
   input wire logic uartTxAct,              // uart tx activity pulse
   input wire logic uartRxAct,              // uart rx activity pulse
   output logic txLedOut,                   // tx led pin level
   output logic txLedOe,                    // tx led drive enable
   output logic rxLedOut,                   // rx led pin level
   output logic rxLedOe                     // rx led drive enable
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   cpf_romode_t romMode_ff, nxt_romMode;
   cpf_runmode_t runMode_ff, nxt_runMode;
   logic fsRst_ff, nxt_fsRst;
   logic rdAct_ff, nxt_rdAct, wrAct_ff, nxt_wrAct;
   logic [7:0] dOut_ff, nxt_dOut;
   logic dOe_ff, nxt_dOe;
   logic [7:0] wrLat_ff, nxt_wrLat;
   logic wrSel_ff, nxt_wrSel;
   logic rxReady_ff, nxt_rxReady;
   logic pinPrev_ff, nxt_pinPrev;
   logic [WAKE_W-1:0] lowCnt_ff, nxt_lowCnt, riCnt_ff, nxt_riCnt;
   logic sendNow_ff, nxt_sendNow, wake_ff, nxt_wake;
   logic txLed_ff, rxLed_ff, nxt_txLed, nxt_rxLed;
   logic txV_ff, nxt_txV;
   logic [7:0] txD_ff, nxt_txD;
   logic txActS, rxActS;
   logic bufInV, bufInR, bufOutV;
   logic [7:0] bufOutD;
   logic pushWr, cpuMode, siwuOn;
   cpf_stat_t stat;

   // byte for a read at the given select
   function automatic logic [7:0] readByte(input logic sel, input cpf_stat_t s, input logic [7:0] d);
      readByte = (sel == SEL_STAT) ? {STAT_UPPER, s.configured, s.suspended, s.txFree, s.rxPresent} : d;
   endfunction

   // ----------------------------------------
   // mode control
   // ----------------------------------------
   always_comb begin
      nxt_romMode = romMode_ff;
      nxt_runMode = runMode_ff;
      nxt_fsRst = fsRst_ff;
      if (eepromValid) begin
         nxt_romMode = eepromMode;
         nxt_runMode = RM_NONE;
         nxt_fsRst = 1'b0;
      end else if (submodeValid && enumerated) begin
         case (interface_submode_cmd)
            SUB_RESET: begin
               nxt_runMode = RM_NONE;
               nxt_fsRst = 1'b0;
            end
            SUB_ABB: nxt_runMode = RM_ABB;
            SUB_SBB: nxt_runMode = RM_SBB;
            SUB_SERENG: nxt_runMode = RM_SERENG;
            SUB_SYNCFIFO: begin
               if (romMode_ff == MD_AFIFO) begin
                  nxt_runMode = RM_SFIFO;
               end
            end
            SUB_FSRST: begin
               if (romMode_ff == MD_FSER) begin
                  nxt_fsRst = 1'b1;
               end
            end
            default: nxt_runMode = runMode_ff;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         romMode_ff <= MD_UART;
         runMode_ff <= RM_NONE;
         fsRst_ff <= 1'b0;
      end else begin
         romMode_ff <= nxt_romMode;
         runMode_ff <= nxt_runMode;
         fsRst_ff <= nxt_fsRst;
      end
   end

   assign cpuMode = (romMode_ff == MD_CPUFIFO) && (runMode_ff == RM_NONE);
   assign siwuOn = (romMode_ff == MD_AFIFO) || (romMode_ff == MD_CPUFIFO)
      || (runMode_ff == RM_ABB) || (runMode_ff == RM_SBB) || (runMode_ff == RM_SFIFO);

   // ----------------------------------------
   // cpu port
   // ----------------------------------------
   assign stat.rxPresent = rxValid;
   assign stat.txFree = bufInR;
   assign stat.suspended = usbSuspend;
   assign stat.configured = usbConfigured;

   always_comb begin
      nxt_rdAct = cpuMode && !chipSelN && !rdN;
      nxt_wrAct = cpuMode && !chipSelN && !wrN;
      nxt_dOe = nxt_rdAct;
      nxt_dOut = readByte(register_select_bit, stat, rxData);
      nxt_rxReady = 1'b0;
      // one pop on the read's leading edge
      if (nxt_rdAct && !rdAct_ff && register_select_bit == SEL_DATA && rxValid) begin
         nxt_rxReady = 1'b1;
      end
      nxt_wrLat = wrLat_ff;
      nxt_wrSel = wrSel_ff;
      if (nxt_wrAct) begin
         nxt_wrLat = dataIn;
         nxt_wrSel = register_select_bit;
      end
   end

   assign pushWr = wrAct_ff && !nxt_wrAct;
   assign bufInV = pushWr && (wrSel_ff == SEL_DATA);

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         rdAct_ff <= 1'b0;
         wrAct_ff <= 1'b0;
         dOe_ff <= 1'b0;
         dOut_ff <= 8'h00;
         rxReady_ff <= 1'b0;
         wrLat_ff <= 8'h00;
         wrSel_ff <= 1'b0;
      end else begin
         rdAct_ff <= nxt_rdAct;
         wrAct_ff <= nxt_wrAct;
         dOe_ff <= nxt_dOe;
         dOut_ff <= nxt_dOut;
         rxReady_ff <= nxt_rxReady;
         wrLat_ff <= nxt_wrLat;
         wrSel_ff <= nxt_wrSel;
      end
   end

   // tx buffer toward usb
   cpf_buf2 u_txbuf (
      .mclk(mclk),
      .resetn(resetn),
      .inValid(bufInV),
      .inReady(bufInR),
      .inData(wrLat_ff),
      .outValid(bufOutV),
      .outReady(!txV_ff || txReady),
      .outData(bufOutD)
   );

   // tx output stage
   always_comb begin
      nxt_txV = txV_ff;
      nxt_txD = txD_ff;
      if (!txV_ff || txReady) begin
         nxt_txV = bufOutV;
         nxt_txD = bufOutD;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         txV_ff <= 1'b0;
         txD_ff <= 8'h00;
      end else begin
         txV_ff <= nxt_txV;
         txD_ff <= nxt_txD;
      end
   end

   // ----------------------------------------
   // flush / wake
   // ----------------------------------------
   always_comb begin
      nxt_pinPrev = flush_or_wake_pin;
      nxt_sendNow = 1'b0;
      nxt_wake = 1'b0;
      nxt_lowCnt = flush_or_wake_pin ? '0 : lowCnt_ff;
      nxt_riCnt = ring_indicator_pin ? '0 : riCnt_ff;
      if (!flush_or_wake_pin && lowCnt_ff != WAKE_W'(WAKE_CYC)) begin
         nxt_lowCnt = lowCnt_ff + WAKE_W'(1);
      end
      if (!ring_indicator_pin && riCnt_ff != WAKE_W'(WAKE_CYC)) begin
         nxt_riCnt = riCnt_ff + WAKE_W'(1);
      end
      // falling edge flags a short packet
      if (siwuOn && pinPrev_ff && !flush_or_wake_pin && !usbSuspend) begin
         nxt_sendNow = 1'b1;
      end
      // cpu send-immediate write
      if (pushWr && wrSel_ff == SEL_STAT) begin
         nxt_sendNow = 1'b1;
      end
      // long low pulse wakes a suspended host
      if (siwuOn && !pullDownEn && usbSuspend
         && lowCnt_ff == WAKE_W'(WAKE_CYC - 1) && !flush_or_wake_pin) begin
         nxt_wake = 1'b1;
      end
      if (romMode_ff == MD_UART && usbSuspend
         && riCnt_ff == WAKE_W'(WAKE_CYC - 1) && !ring_indicator_pin) begin
         nxt_wake = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         pinPrev_ff <= 1'b1;
         lowCnt_ff <= '0;
         riCnt_ff <= '0;
         sendNow_ff <= 1'b0;
         wake_ff <= 1'b0;
      end else begin
         pinPrev_ff <= nxt_pinPrev;
         lowCnt_ff <= nxt_lowCnt;
         riCnt_ff <= nxt_riCnt;
         sendNow_ff <= nxt_sendNow;
         wake_ff <= nxt_wake;
      end
   end

   // ----------------------------------------
   // activity leds
   // ----------------------------------------
   cpf_oneshot u_txshot (
      .mclk(mclk),
      .resetn(resetn),
      .trig(uartTxAct),
      .active(txActS)
   );

   cpf_oneshot u_rxshot (
      .mclk(mclk),
      .resetn(resetn),
      .trig(uartRxAct),
      .active(rxActS)
   );

   always_comb begin
      nxt_txLed = (romMode_ff == MD_UART) && txActS;
      nxt_rxLed = (romMode_ff == MD_UART) && rxActS;
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         txLed_ff <= 1'b0;
         rxLed_ff <= 1'b0;
      end else begin
         txLed_ff <= nxt_txLed;
         rxLed_ff <= nxt_rxLed;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign dataOut = dOut_ff;
   assign dataOe = dOe_ff;
   assign rxReady = rxReady_ff;
   assign txValid = txV_ff;
   assign txData = txD_ff;
   assign sendNowReq = sendNow_ff;
   assign wakeReq = wake_ff;
   assign fastSerRst = fsRst_ff;
   assign romMode = romMode_ff;
   assign runMode = runMode_ff;
   assign txLedOut = 1'b0;
   assign rxLedOut = 1'b0;
   assign txLedOe = txLed_ff;
   assign rxLedOe = rxLed_ff;
endmodule

// ===== rtl/cpf_oneshot.sv
// cpf_oneshot: retriggerable one-shot stretching activity into an led pulse
`timescale 1ns/1ps
module cpf_oneshot
   import cpf_pkg::*;
(
   input wire logic mclk,    // clock
   input wire logic resetn,  // sync reset, low
   input wire logic trig,    // activity pulse
   output logic active       // stretched activity
);
   logic [LED_W-1:0] cnt_ff, nxt_cnt;

   // reload on activity, count down otherwise
   always_comb begin
      nxt_cnt = cnt_ff;
      if (trig) begin
         nxt_cnt = LED_W'(LED_CYC);
      end else if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - LED_W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign active = (cnt_ff != '0);
endmodule

// ===== test/cpf_cpu_model.sv
// cpf_cpu_model: external cpu driving the parallel host port
`timescale 1ns/1ps
module cpf_cpu_model (
   input wire logic mclk,             // clock
   output logic chipSelN,             // chip select, low
   output logic register_select_bit,  // pipe or status
   output logic rdN,                  // read strobe, low
   output logic wrN,                  // write strobe, low
   output logic [7:0] dataIn,         // cpu data out
   input wire logic [7:0] dataOut,    // port data
   input wire logic dataOe            // port drives bus
);
   logic [7:0] busLvl;
   // undriven bus shows the inverse of the cpu's last byte
   assign busLvl = dataOe ? dataOut : ~dataIn;
   initial begin
      chipSelN = 1'b1;
      register_select_bit = 1'b0;
      rdN = 1'b1;
      wrN = 1'b1;
      dataIn = 8'h00;
   end
   // ----------------------------------------
   // one bus cycle, entered just after a rising edge
   // ----------------------------------------
   task automatic xfer(input logic csN, input logic wr, input logic sel, input logic [7:0] d,
         input int len, output logic [7:0] q);
      chipSelN <= csN;
      register_select_bit <= sel;
      dataIn <= d;
      rdN <= wr;
      wrN <= !wr;
      repeat (len) @(posedge mclk); // strobe low two cycles or more
      q = busLvl;
      chipSelN <= 1'b1;
      rdN <= 1'b1;
      wrN <= 1'b1;
      dataIn <= ~d;
      @(posedge mclk); // strobe high one cycle at least
   endtask
endmodule

// ===== test/cpf_host_port_asserts.sv
// cpf_host_port_asserts: port-level checks of the cpu-style fifo host port
`timescale 1ns/1ps
module cpf_host_port_asserts
   import cpf_pkg::*;
(
   input wire logic mclk,                   // clock
   input wire logic resetn,                 // sync reset, low
   input wire logic chipSelN,               // chip select
   input wire logic register_select_bit,    // pipe or status
   input wire logic rdN,                    // read strobe
   input wire logic [7:0] dataOut,          // read byte
   input wire logic dataOe,                 // bus drive
   input wire logic submodeValid,           // submode pulse
   input wire logic [7:0] interface_submode_cmd, // submode code
   input wire logic usbSuspend,             // suspended
   input wire logic usbConfigured,          // configured
   input wire logic rxValid,                // rx byte ready
   input wire logic rxReady,                // rx pop
   input wire logic sendNowReq,             // short packet
   input wire cpf_romode_t romMode,         // stored mode
   input wire cpf_runmode_t runMode,        // software mode
   input wire logic flush_or_wake_pin,      // flush/wake
   input wire logic uartTxAct,              // tx activity
   input wire logic txLedOut,               // tx led level
   input wire logic txLedOe,                // tx led drive
   input wire logic rxLedOe                 // rx led drive
);
   // ----------------------------------------
   // shared clocking and sequences
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   sequence rdAct;
      !chipSelN && !rdN && romMode == MD_CPUFIFO && runMode == RM_NONE;
   endsequence
   sequence flushEdge;
      $fell(flush_or_wake_pin) && !usbSuspend && romMode inside {MD_AFIFO, MD_CPUFIFO}
         && runMode inside {RM_NONE, RM_ABB, RM_SBB};
   endsequence
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   chk_cs_ignore: assert property (chipSelN && $past(chipSelN) |-> !dataOe)
      else $error("bus driven while deselected");
   chk_read_drive: assert property (rdAct |=> dataOe)
      else $error("read not answered");
   chk_stat_byte: assert property (dataOe && $past(register_select_bit) |-> dataOut[7:4] == STAT_UPPER
      && dataOut[3:2] == {$past(usbConfigured), $past(usbSuspend)} && dataOut[0] == $past(rxValid))
      else $error("status byte wrong");
   chk_one_pop: assert property (rxReady |-> !$past(register_select_bit) && $past(rxValid) ##1 !rxReady)
      else $error("bad pop");
   chk_send_pulse: assert property (sendNowReq |=> !sendNowReq)
      else $error("send request too long");
   chk_flush_now: assert property (flushEdge |-> ##[1:3] sendNowReq)
      else $error("flush edge lost");
   chk_led_on: assert property (uartTxAct && romMode == MD_UART |-> ##[1:2] txLedOe && !txLedOut)
      else $error("tx led not lit");
   chk_led_hold: assert property ($rose(rxLedOe) |-> rxLedOe[*8])
      else $error("rx led not stretched");
   chk_sync_guard: assert property (submodeValid && interface_submode_cmd == SUB_SYNCFIFO
      && romMode != MD_AFIFO |=> runMode != RM_SFIFO)
      else $error("sync fifo entered");
endmodule

bind cpf_host_port cpf_host_port_asserts chk (.mclk(mclk), .resetn(resetn), .chipSelN(chipSelN),
   .register_select_bit(register_select_bit), .rdN(rdN), .dataOut(dataOut), .dataOe(dataOe),
   .submodeValid(submodeValid), .interface_submode_cmd(interface_submode_cmd), .usbSuspend(usbSuspend),
   .usbConfigured(usbConfigured), .rxValid(rxValid), .rxReady(rxReady), .sendNowReq(sendNowReq),
   .romMode(romMode), .runMode(runMode), .flush_or_wake_pin(flush_or_wake_pin), .uartTxAct(uartTxAct),
   .txLedOut(txLedOut), .txLedOe(txLedOe), .rxLedOe(rxLedOe));

// ===== test/cpf_host_port_tb_top.sv
// cpf_host_port_tb_top: self-checking bench for the cpu-style fifo host port
`timescale 1ns/1ps
module cpf_host_port_tb_top
   import cpf_pkg::*;
;
   logic mclk, resetn, eepromValid, pullDownEn, submodeValid, enumerated, usbSuspend, usbConfigured;
   logic rxValid, txReady, flush_or_wake_pin, ring_indicator_pin, uartTxAct, uartRxAct, chipSelN;
   logic register_select_bit, rdN, wrN, dataOe, rxReady, txValid, sendNowReq, wakeReq, fastSerRst;
   logic txLedOut, txLedOe, rxLedOut, rxLedOe;
   logic [7:0] dataIn, dataOut, interface_submode_cmd, rxData, txData, q;
   cpf_romode_t eepromMode, romMode;
   cpf_runmode_t runMode;
   logic [31:0] lfsr;
   int failures, num_checks, pops, sends, i, b;
   logic [7:0] txq[$];
   logic [7:0] subCodes[4] = '{SUB_ABB, SUB_SBB, SUB_SERENG, SUB_SYNCFIFO};
   cpf_runmode_t subModes[4] = '{RM_ABB, RM_SBB, RM_SERENG, RM_SFIFO};
   cpf_host_port DUT (.mclk(mclk), .resetn(resetn), .chipSelN(chipSelN), .register_select_bit(register_select_bit),
      .rdN(rdN), .wrN(wrN), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .eepromValid(eepromValid),
      .eepromMode(eepromMode), .pullDownEn(pullDownEn), .submodeValid(submodeValid),
      .interface_submode_cmd(interface_submode_cmd), .enumerated(enumerated), .usbSuspend(usbSuspend),
      .usbConfigured(usbConfigured), .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData), .txValid(txValid),
      .txReady(txReady), .txData(txData), .sendNowReq(sendNowReq), .wakeReq(wakeReq), .fastSerRst(fastSerRst),
      .romMode(romMode), .runMode(runMode), .flush_or_wake_pin(flush_or_wake_pin),
      .ring_indicator_pin(ring_indicator_pin), .uartTxAct(uartTxAct), .uartRxAct(uartRxAct),
      .txLedOut(txLedOut), .txLedOe(txLedOe), .rxLedOut(rxLedOut), .rxLedOe(rxLedOe));
   cpf_cpu_model cpu (.mclk(mclk), .chipSelN(chipSelN), .register_select_bit(register_select_bit), .rdN(rdN),
      .wrN(wrN), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));
   // ----------------------------------------
   // clock, helpers
   // ----------------------------------------
   initial mclk = 1'b0;
   always #50 mclk = ~mclk;
   function automatic logic [31:0] nxt_rand(input logic [31:0] r);
      return {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
   endfunction
   function automatic logic [7:0] exp_stat(input logic c, input logic s, input logic t, input logic r);
      return {4'h0, c, s, t, r};
   endfunction
   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic pulse_sub(input logic [7:0] code);
      submodeValid <= 1'b1;
      interface_submode_cmd <= code;
      tick(1);
      submodeValid <= 1'b0;
      tick(2);
   endtask
   task automatic load_rom(input cpf_romode_t m);
      eepromValid <= 1'b1;
      eepromMode <= m;
      tick(1);
      eepromValid <= 1'b0;
      tick(2);
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // count pops and send requests, score the tx stream
   always @(posedge mclk) begin
      if (rxReady === 1'b1) pops++;
      if (sendNowReq === 1'b1) sends++;
      if (wakeReq !== 1'b0 && resetn === 1'b1) chk("wake request", 8'h01, 8'h00);
      if (txValid === 1'b1 && txReady === 1'b1) begin
         if (txq.size() == 0) chk("stray tx byte", 8'h01, 8'h00);
         else chk("tx byte", txData, txq.pop_front());
      end
   end
   initial begin
      tick(5000);
      failures++;
      final_report();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      lfsr = 32'hf041a380;
      {resetn, eepromValid, pullDownEn, submodeValid, enumerated, usbSuspend, usbConfigured} = '0;
      {rxValid, txReady, uartTxAct, uartRxAct, rxData, interface_submode_cmd} = '0;
      {flush_or_wake_pin, ring_indicator_pin} = 2'b11;
      eepromMode = MD_UART;
      tick(6);
      resetn <= 1'b1;
      tick(2);
      chk("rom mode", 8'(romMode), 8'(MD_UART));
      uartTxAct <= 1'b1;
      tick(1);
      uartTxAct <= 1'b0;
      tick(3);
      chk("tx led", {5'h0, txLedOe, txLedOut, rxLedOe}, 8'h04);
      uartRxAct <= 1'b1;
      tick(1);
      uartRxAct <= 1'b0;
      tick(12);
      chk("leds held", {6'h0, txLedOe, rxLedOe}, 8'h03);
      pulse_sub(SUB_ABB);
      chk("early submode", 8'(runMode), 8'(RM_NONE));
      enumerated <= 1'b1;
      load_rom(MD_FSER);
      pulse_sub(SUB_FSRST);
      chk("fast serial reset", {7'h0, fastSerRst}, 8'h01);
      pulse_sub(SUB_RESET);
      chk("fast serial run", {7'h0, fastSerRst}, 8'h00);
      load_rom(MD_CPUFIFO);
      pulse_sub(SUB_SYNCFIFO);
      chk("sync fifo refused", 8'(runMode), 8'(RM_NONE));
      load_rom(MD_AFIFO);
      for (i = 0; i < 4; i++) begin
         pulse_sub(subCodes[i]);
         chk("run mode", 8'(runMode), 8'(subModes[i]));
         b = sends;
         flush_or_wake_pin <= 1'b0;
         tick(3);
         flush_or_wake_pin <= 1'b1;
         tick(3);
         if (i != 2) chk("flush", 8'(sends - b), 8'h01);
      end
      load_rom(MD_CPUFIFO);
      chk("rom mode", 8'(romMode), 8'(MD_CPUFIFO));
      // fill the tx path with the usb side stalled, past the point of refusal
      for (i = 0; i < 5; i++) begin
         lfsr = nxt_rand(lfsr);
         usbSuspend <= lfsr[10];
         usbConfigured <= lfsr[11];
         cpu.xfer(1'b0, 1'b0, 1'b1, 8'h00, 2, q);
         chk("status", q & 8'h0f, exp_stat(usbConfigured, usbSuspend, txq.size() < 3, rxValid));
         if (txq.size() < 3) txq.push_back(lfsr[7:0]);
         cpu.xfer(1'b0, 1'b1, 1'b0, lfsr[7:0], 2 + lfsr[9:8], q);
      end
      chk("tx refused", 8'(txq.size()), 8'h03);
      usbSuspend <= 1'b0;
      b = sends;
      cpu.xfer(1'b1, 1'b1, 1'b1, 8'h5a, 3, q);
      cpu.xfer(1'b1, 1'b1, 1'b0, 8'ha5, 3, q);
      chk("deselected send", 8'(sends - b), 8'h00);
      for (i = 0; i < 40; i++) begin
         lfsr = nxt_rand(lfsr);
         txReady <= lfsr[0];
         tick(1);
      end
      txReady <= 1'b1;
      tick(4);
      chk("tx drained", 8'(txq.size()), 8'h00);
      b = sends;
      cpu.xfer(1'b0, 1'b1, 1'b1, 8'h00, 2, q);
      tick(3);
      chk("send now", 8'(sends - b), 8'h01);
      for (i = 0; i < 3; i++) begin
         lfsr = nxt_rand(lfsr);
         rxValid <= 1'b1;
         rxData <= lfsr[7:0];
         b = pops;
         cpu.xfer(1'b0, 1'b0, 1'b0, 8'h00, 2 + i, q);
         chk("rx byte", q, lfsr[7:0]);
         chk("pops", 8'(pops - b), 8'h01);
      end
      rxValid <= 1'b0;
      tick(3);
      final_report();
   end
endmodule
